/* bench/pef_event_flags_test.sv */
`timescale 1ns/100ps
module pef_event_flags_test
   import pef_pkg::*;
;
   // ==========================================
   // Stimulus and observed signals
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
   logic        normalMode, calcDone, syncSeen, syncAcc, simClr, halt, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, listenTimeout;
   logic [15:0] ev;
   logic [3:0]  syncMax;
   int          nMismatch, checks;
   // Flags expected for each event line, fatal causes add bit 15
   localparam logic [15:0] EXP [16] = '{16'h8020, 16'h8040, 16'h8008, 16'h8010,
      16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0200, 16'h0080, 16'h0080,
      16'h0004, 16'h0002, 16'h0001, 16'h2000, 16'h4000};

   pef_event_flags #(.SYNC_W(4)) pef_event_flags_inst (.clk_sys(clk_sys), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .normalMode(normalMode),
      .latestTxViolA(ev[0]), .latestTxViolB(ev[1]), .slotCrossA(ev[2]),
      .slotCrossB(ev[3]), .calcRequest(ev[15]), .calcDone(calcDone),
      .configComplete(ev[14]), .listenTimeout(listenTimeout),
      .coldStartExhausted(ev[4]), .cycleEnd(ev[5]), .rateMeasShort(ev[5]),
      .offsetMeasShort(ev[6]), .offsetLimitHit(ev[7]), .rateLimitHit(ev[8]),
      .syncFrameSeen(syncSeen), .syncFrameAccepted(syncAcc), .syncMax(syncMax),
      .testSymbolA(ev[9]), .testSymbolB(ev[10]), .timerOneExpired(ev[12]),
      .timerTwoExpired(ev[11]), .cycleStart(ev[13]), .protocolHaltState(halt),
      .protocolEventIrq(irq));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; simClr raises a cycle start during the access phase
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      if (simClr) ev[13] <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n == 50) nMismatch++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      ev <= 16'h0000;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, q, exp);
   endtask

   // Calc request lingers a second cycle so it lands while busy
   task automatic fire(input int k);
      ev[k] <= 1'b1;
      listenTimeout <= (k == 14) ? 32'h0 : 32'h10;
      @(posedge clk_sys);
      if (k == 15) @(posedge clk_sys);
      ev <= 16'h0000;
      listenTimeout <= 32'h10;
      @(posedge clk_sys);
   endtask

   task automatic sync(input logic acc);
      syncSeen <= 1'b1;
      syncAcc <= acc;
      @(posedge clk_sys);
      syncSeen <= 1'b0;
      syncAcc <= 1'b0;
      @(posedge clk_sys);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      rd(PEF_OFF_FLAGS0, 32'h0, "flags");
      rd(PEF_OFF_ENABLE0, 32'h0, "enable");
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      chk("halt", {31'h0, halt}, 32'h0);
      rd(PEF_OFF_STATUS, 32'h0, "status idle");
   endtask

   task automatic t_write_bits;
      fire(13);
      fire(12);
      wr(PEF_OFF_FLAGS0, 32'hFFFF0002);
      rd(PEF_OFF_FLAGS0, 32'h1, "clear one");
      wr(PEF_OFF_FLAGS0, 32'h0);
      rd(PEF_OFF_FLAGS0, 32'h1, "write zero");
      simClr = 1'b1;
      wr(PEF_OFF_FLAGS0, 32'h1);
      simClr = 1'b0;
      rd(PEF_OFF_FLAGS0, 32'h1, "set beats clear");
   endtask

   task automatic t_mode_irq;
      normalMode <= 1'b0;
      wr(PEF_OFF_ENABLE0, 32'h1);
      wr(PEF_OFF_FLAGS0, 32'h1);
      rd(PEF_OFF_FLAGS0, 32'h1, "write outside normal");
      chk("irq on", {31'h0, irq}, 32'h1);
      normalMode <= 1'b1;
      wr(PEF_OFF_ENABLE0, 32'h2);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(PEF_OFF_FLAGS0, 32'h1);
      rd(PEF_OFF_FLAGS0, 32'h0, "write in normal");
   endtask

   task automatic t_sync;
      fire(13);
      wr(PEF_OFF_FLAGS0, 32'h1);
      repeat (3) sync(1'b0);
      rd(PEF_OFF_FLAGS0, 32'h0, "filtered sync");
      repeat (2) sync(1'b1);
      rd(PEF_OFF_FLAGS0, 32'h0, "sync at max");
      sync(1'b1);
      rd(PEF_OFF_FLAGS0, 32'h100, "sync over max");
      wr(PEF_OFF_FLAGS0, 32'h100);
   endtask

   // Fatal causes last, since halt only leaves on reset
   task automatic t_each_event;
      int k;
      for (int i = 0; i < 16; i++) begin
         k = (i + 4) % 16;
         fire(k);
         rd(PEF_OFF_FLAGS0, {16'h0, EXP[k]}, "event flag");
         chk("halt", {31'h0, halt}, {31'h0, i >= 10});
         wr(PEF_OFF_FLAGS0, {16'h0, EXP[k]});
         rd(PEF_OFF_FLAGS0, 32'h0, "cleared");
      end
      rd(PEF_OFF_STATUS, 32'h3, "status halted busy");
   endtask

   // ==========================================
   // Run control
   task automatic complete_run;
      $display("mismatches %0d checks %0d", nMismatch, checks);
      if (nMismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      nMismatch++;
      complete_run;
   end

   initial begin
      {rstn, psel, penable, pwrite, calcDone, syncSeen, syncAcc, simClr} = '0;
      {paddr, pwdata, ev} = '0;
      normalMode = 1'b1;
      listenTimeout = 32'h10;
      syncMax = 4'h2;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset;
      t_write_bits;
      t_mode_irq;
      t_sync;
      t_each_event;
      complete_run;
   end
endmodule

/* hdl/pef_event_flags.sv */
`timescale 1ns/100ps
module pef_event_flags
   import pef_pkg::*;
#(
   parameter int SYNC_W = 4
)(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Controller state
   input  wire logic              normalMode,
   // Protocol engine events, one-cycle pulses; listenTimeout and syncMax are values
   input  wire logic              latestTxViolA,
   input  wire logic              latestTxViolB,
   input  wire logic              slotCrossA,
   input  wire logic              slotCrossB,
   input  wire logic              calcRequest,
   input  wire logic              calcDone,
   input  wire logic              configComplete,
   input  wire logic [31:0]       listenTimeout,
   input  wire logic              coldStartExhausted,
   input  wire logic              cycleEnd,
   input  wire logic              rateMeasShort,
   input  wire logic              offsetMeasShort,
   input  wire logic              offsetLimitHit,
   input  wire logic              rateLimitHit,
   input  wire logic              syncFrameSeen,
   input  wire logic              syncFrameAccepted,
   input  wire logic [SYNC_W-1:0] syncMax,
   input  wire logic              testSymbolA,
   input  wire logic              testSymbolB,
   input  wire logic              timerOneExpired,
   input  wire logic              timerTwoExpired,
   input  wire logic              cycleStart,
   // Outputs
   output logic                   protocolHaltState,
   output logic                   protocolEventIrq
);
   // ==========================================
   // Reset release
   logic rstMeta_n;
   logic rstSync_n;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // ==========================================
   // APB decode
   pef_flag_if fb ();
   logic [15:0] enable;
   logic        calcBusy;
   logic [SYNC_W:0] syncCount;

   wire apbAccess = psel && penable;
   wire apbWrite  = apbAccess && pwrite;
   wire hitFlags  = (paddr == PEF_OFF_FLAGS0);
   wire hitEnable = (paddr == PEF_OFF_ENABLE0);
   wire hitStatus = (paddr == PEF_OFF_STATUS);
   wire hitAny    = hitFlags || hitEnable || hitStatus;
   // Flag writes outside normal mode are dropped without an error response
   wire flagWrite = apbWrite && hitFlags && normalMode;

   assign pready  = 1'b1;
   assign pslverr = apbAccess && !hitAny;

   wire [31:0] next_prdata = hitFlags  ? {16'h0000, fb.flags} :
                             hitEnable ? {16'h0000, enable} :
                             hitStatus ? {30'h00000000, calcBusy, protocolHaltState} :
                             32'h00000000;

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= next_prdata;
   end

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
         enable <= PEF_RST_ENABLE;
      else if (apbWrite && hitEnable)
         enable <= pwdata[15:0];
   end

   // ==========================================
   // Event detection
   wire fatalEv  = latestTxViolA || latestTxViolB || slotCrossA || slotCrossB;
   wire internEv = calcRequest && calcBusy && !calcDone;
   wire badCfgEv = configComplete && (listenTimeout == 32'h00000000);
   wire climitEv = offsetLimitHit || rateLimitHit;
   // Count saturates one above the largest syncMax value, enough to trip the check
   wire syncCnt  = syncFrameSeen && syncFrameAccepted;
   wire [SYNC_W:0] next_syncCount = syncCount + {{SYNC_W{1'b0}}, 1'b1};
   wire syncOverEv = syncCnt && (next_syncCount > {1'b0, syncMax})
                     && (syncCount <= {1'b0, syncMax});

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
         calcBusy <= 1'b0;
      else if (calcRequest)
         calcBusy <= 1'b1;
      else if (calcDone)
         calcBusy <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
         syncCount <= '0;
      else if (cycleStart)
         syncCount <= '0;
      else if (syncCnt && !syncCount[SYNC_W])
         syncCount <= next_syncCount;
   end

   logic [15:0] setVec;
   always_comb begin
      setVec = 16'h0000;
      setVec[PEF_B_FATAL]   = fatalEv;
      setVec[PEF_B_INTERN]  = internEv;
      setVec[PEF_B_BADCFG]  = badCfgEv;
      setVec[PEF_B_CSABORT] = coldStartExhausted;
      setVec[PEF_B_MRATE]   = cycleEnd && rateMeasShort;
      setVec[PEF_B_MOFFS]   = offsetMeasShort;
      setVec[PEF_B_CLIMIT]  = climitEv;
      setVec[PEF_B_MSYNC]   = syncOverEv;
      setVec[PEF_B_TSYM]    = testSymbolA || testSymbolB;
      setVec[PEF_B_LTXB]    = latestTxViolB;
      setVec[PEF_B_LTXA]    = latestTxViolA;
      setVec[PEF_B_TBCB]    = slotCrossB;
      setVec[PEF_B_TBCA]    = slotCrossA;
      setVec[PEF_B_TIM2]    = timerTwoExpired;
      setVec[PEF_B_TIM1]    = timerOneExpired;
      setVec[PEF_B_CYS]     = cycleStart;
   end

   assign fb.setEv   = setVec;
   assign fb.clrMask = flagWrite ? pwdata[15:0] : 16'h0000;

   pef_flag_bank u_bank (
      .clk       (clk_sys),
      .rstSync_n (rstSync_n),
      .fb        (fb)
   );

   // ==========================================
   // Halt: sticky until reset, since only a reset leaves the halt state here
   wire haltEv = fatalEv || internEv || badCfgEv;
   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n)
         protocolHaltState <= 1'b0;
      else if (haltEv)
         protocolHaltState <= 1'b1;
   end

   assign protocolEventIrq = |(fb.flags & enable);

   // ==========================================
   // Checks
   a_fatal_halt: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (latestTxViolA || latestTxViolB || slotCrossA || slotCrossB) |=>
         (protocolHaltState && fb.flags[PEF_B_FATAL]))
      else $error("fatal event without halt");
   a_intern_halt: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (calcRequest && calcBusy && !calcDone) |=>
         (fb.flags[PEF_B_INTERN] && protocolHaltState))
      else $error("internal error missed");
   a_badcfg_zero: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (configComplete && listenTimeout == 32'h00000000) |=>
         (fb.flags[PEF_B_BADCFG] && protocolHaltState))
      else $error("zero listen timeout accepted");
   a_rate_cycle: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (!$past(fb.flags[PEF_B_MRATE]) && fb.flags[PEF_B_MRATE]) |->
         $past(cycleEnd && rateMeasShort))
      else $error("rate flag set outside cycle end");
   a_write_mode: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (apbWrite && hitFlags && !normalMode) |=> (fb.flags == ($past(fb.flags) | $past(setVec))))
      else $error("flag write taken outside normal mode");
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      ((fb.flags & enable) == 16'h0000) |-> !protocolEventIrq)
      else $error("irq without enabled flag");
   a_sync_over: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (syncFrameSeen && !syncFrameAccepted && !fb.flags[PEF_B_MSYNC]) |=>
         !fb.flags[PEF_B_MSYNC])
      else $error("rejected sync frame counted");
   a_test_sym: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
      (testSymbolB || testSymbolA) |=> fb.flags[PEF_B_TSYM] ##1 1'b1)
      else $error("test symbol flag missed");
endmodule

/* hdl/pef_flag_bank.sv */
`timescale 1ns/100ps
module pef_flag_bank
   import pef_pkg::*;
(
   input wire logic clk,
   input wire logic rstSync_n,
   pef_flag_if.bank fb
);
   logic [15:0] flags;
   genvar i;
   // ==========================================
   // Sticky flags, set beats clear
   generate
      for (i = 0; i < PEF_NFLAGS; i++) begin : g_flag
         always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n)
               flags[i] <= PEF_RST_FLAGS[i];
            else if (fb.setEv[i])
               flags[i] <= 1'b1;
            else if (fb.clrMask[i])
               flags[i] <= 1'b0;
         end
      end
   endgenerate
   assign fb.flags = flags;

   a_set_wins: assert property (@(posedge clk) disable iff (!rstSync_n)
      (fb.setEv != 16'h0000) |=> ((flags & $past(fb.setEv)) == $past(fb.setEv)))
      else $error("set event lost");
   a_clear_ones: assert property (@(posedge clk) disable iff (!rstSync_n)
      (fb.clrMask != 16'h0000) |=>
         ((flags & $past(fb.clrMask) & ~$past(fb.setEv)) == 16'h0000))
      else $error("cleared flag still set");
   a_zero_keeps: assert property (@(posedge clk) disable iff (!rstSync_n)
      1'b1 |=> ((flags & ~$past(fb.clrMask) & $past(flags)) == ($past(flags) & ~$past(fb.clrMask))))
      else $error("flag lost without clear");
endmodule

/* hdl/pef_flag_if.sv */
`timescale 1ns/100ps
interface pef_flag_if;
   logic [15:0] setEv;
   logic [15:0] clrMask;
   logic [15:0] flags;
   modport ctrl (output setEv, output clrMask, input flags);
   modport bank (input setEv, input clrMask, output flags);
endinterface

/* hdl/pef_pkg.sv */
// Contract
// - Writing one clears that flag bit; the code clears it only while normalMode is high and drops the write otherwise
// - Writing zero leaves flag unchanged
// - Set wins over simultaneous clear
// - Bit 15 fatal error, then halt
// - Fatal: late transmit or slot crossing
// - Bit 14 internal error, then halt
// - Internal error: new calc while busy
// - Bit 13 bad config, then halt
// - Config complete with zero listen timeout
// - Bit 12 cold-start attempts exhausted
// - Bit 11 missing rate fix, cycle end
// - Bit 10 missing offset fix
// - Bit 9 correction at or over limit
// - Bit 8 sync count above maximum
// - Count only filter-accepted sync frames
// - Bit 7 test symbol on either channel
// - Bit 6 channel B dynamic overrun
// - Bit 5 channel A dynamic overrun
// - Bit 4 channel B slot crossing
// - Bit 3 channel A slot crossing
// - Bit 2 second timer expired
// - Bit 1 first timer expired
// - Bit 0 cycle start
package pef_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0]  PEF_OFF_FLAGS0  = 8'h18;
   localparam logic [7:0]  PEF_OFF_ENABLE0 = 8'h10;
   localparam logic [7:0]  PEF_OFF_STATUS  = 8'h1C;
   localparam logic [15:0] PEF_RST_FLAGS   = 16'h0000;
   localparam logic [15:0] PEF_RST_ENABLE  = 16'h0000;
   localparam int PEF_NFLAGS = 16;
   // ==========================================
   // Flag positions
   localparam int PEF_B_FATAL   = 15;
   localparam int PEF_B_INTERN  = 14;
   localparam int PEF_B_BADCFG  = 13;
   localparam int PEF_B_CSABORT = 12;
   localparam int PEF_B_MRATE   = 11;
   localparam int PEF_B_MOFFS   = 10;
   localparam int PEF_B_CLIMIT  = 9;
   localparam int PEF_B_MSYNC   = 8;
   localparam int PEF_B_TSYM    = 7;
   localparam int PEF_B_LTXB    = 6;
   localparam int PEF_B_LTXA    = 5;
   localparam int PEF_B_TBCB    = 4;
   localparam int PEF_B_TBCA    = 3;
   localparam int PEF_B_TIM2    = 2;
   localparam int PEF_B_TIM1    = 1;
   localparam int PEF_B_CYS     = 0;
endpackage
